// ==== rtl/dcl_lock_decode.sv ====
// Turns one channel's pair of lock bits into four write permissions.
// Assumes the lock bits come from flip-flops of the register bank.
`timescale 1ns/10ps

module dcl_lock_decode (
  // Lock bits of the channel.
  input  wire logic dataLock,
  input  wire logic cfgLock,
  // Permissions.
  output logic      volCodeOk,
  output logic      nvCodeOk,
  output logic      volCfgOk,
  output logic      nvCfgOk
);
  import dcl_pkg::*;

  // ==========================================================================
  // Permission table.
  always_comb begin
    volCodeOk = !dataLock;               // R02 R03 R04 R05
    nvCodeOk  = !dataLock && !cfgLock;   // R02 R03 R04 R05
    volCfgOk  = !(dataLock && cfgLock);  // R02 R03 R04 R05
    nvCfgOk   = !dataLock && !cfgLock;   // R02 R03 R04 R05
  end

endmodule

// ==== rtl/dcl_lock_regs.svh ====
// Register offsets, field positions, reset values and codes of the converter register bank.
// Included by the package and by the top and reference-decode design files; holds definitions only.
`ifndef DCL_LOCK_REGS_SVH
`define DCL_LOCK_REGS_SVH

// ==========================================================================
// Device size.
`define DCL_CHANS          2
`define DCL_RES            12
`define DCL_FLD_W          2

// ==========================================================================
// Register addresses of the serial command port.
`define DCL_ADDR_W         5
`define DCL_A_VOL_DAC0     5'h00
`define DCL_A_VOL_REF      5'h08
`define DCL_A_VOL_PD       5'h09
`define DCL_A_VOL_GAIN     5'h0a
`define DCL_A_LOCK_STAT    5'h0b
`define DCL_A_NV_DAC0      5'h10
`define DCL_A_NV_REF       5'h18
`define DCL_A_NV_PD        5'h19
`define DCL_A_NV_GAIN      5'h1a

// ==========================================================================
// Output codes.
`define DCL_CODE_FULL      12'hfff
`define DCL_CODE_MID       12'h7ff
`define DCL_CODE_ZERO      12'h000
`define DCL_CODE_FULL_10   10'h3ff
`define DCL_CODE_MID_10    10'h1ff
`define DCL_CODE_FULL_8    8'hff
`define DCL_CODE_MID_8     8'h7f

// ==========================================================================
// Field positions and values.
`define DCL_GAIN_LSB       8
`define DCL_POR_BIT        7
`define DCL_SLAVE_ADDRESS_LOCK_BIT      7
`define DCL_LOCK_DL_OFS    1
`define DCL_LOCK_CL_OFS    0
`define DCL_BUS_ADDR_W     7
`define DCL_BUS_ADDR_RST   7'h60
`define DCL_SLAVE_ADDRESS_LOCK_RST      1'h1
`define DCL_REF_SUPPLY     2'h0
`define DCL_REF_BANDGAP    2'h1
`define DCL_REF_EXT_UNBUF  2'h2
`define DCL_REF_EXT_BUF    2'h3
`define DCL_PD_NORMAL      2'h0
`define DCL_WORD_W         16
`define DCL_WORD_ZERO      16'h0000
`define DCL_WORD_RESERVED  16'hffff

`endif

// ==== rtl/dcl_lock_top.sv ====
// Register bank and write-lock logic of a two-channel 12-bit voltage-output converter.
// Assumes commands arrive already decoded from the serial interface, synchronous to clk.
//
// Operation
// R01: Address-lock set refuses changes to stored seven-bit slave address; clear allows them.
// R02: Lock bits 11 block both code copies and both configuration copies.
// R03: Lock bits 10 leave only volatile configuration writable.
// R04: Lock bits 01 allow volatile code and configuration, reject nonvolatile copies.
// R05: Lock bits 00 allow writes to every code and configuration location.
// R06: Configuration means reference-select, power-down and gain bits of the channel.
// R07: Each channel's two lock bits are readable in a lock status field.
// R08: Output codes hold device resolution, right-aligned at bit 0 of the word.
// R09: Code bits above the resolution are unimplemented and read zero.
// R10: 12-bit full, mid and zero scale are FFFh, 7FFh and 000h.
// R11: 10-bit full and mid scale are 3FFh and 1FFh, zero at zero.
// R12: 8-bit full and mid scale are FFh and 7Fh, zero at zero.
// R13: Reference-select register has two bits per channel, channel 0 lowest.
// R14: Reference codes: 11 pin buffered, 10 pin unbuffered, 01 band gap, 00 supply.
// R15: Band gap selection keeps the reference driven while the channel is powered down.
// R16: Controller should pair supply reference with power-down for lowest current.
// R17: Reference-select exists as volatile and nonvolatile copies with equal layout.
// R18: Controller changes lock bits only with high-voltage pin raised plus enable/disable.
// R19: Enable/disable at volatile code address moves config lock, nonvolatile moves data lock.
// R20: Address-lock bit moves only by enable/disable naming the stored gain/address register.
// R21: Power-on or brown-out keeps locks and copies stored codes into volatile codes.
// R22: A write to a locked location leaves its contents unchanged.
`timescale 1ns/10ps
`include "dcl_lock_regs.svh"

module dcl_lock_top (
  // Clock and reset.
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // Supply events.
  input  wire logic                                  porEvent,
  input  wire logic                                  highVoltageCmdPin,
  // Command request.
  input  wire logic                                  cmdValid,
  output logic                                       cmdReady,
  input  wire dcl_pkg::dcl_cmd_t                     cmdKind,
  input  wire logic [`DCL_ADDR_W-1:0]                cmdAddr,
  input  wire logic [`DCL_WORD_W-1:0]                cmdData,
  // Command answer.
  output logic                                       rspValid,
  output logic                                       rspNack,
  output logic [`DCL_WORD_W-1:0]                     rdData,
  // Channel state.
  output logic [`DCL_CHANS-1:0][`DCL_RES-1:0]        outputCode,
  output logic [`DCL_CHANS-1:0][`DCL_FLD_W-1:0]      powerDownField,
  output logic [`DCL_CHANS-1:0]                      outputGainBit,
  output logic [`DCL_CHANS-1:0][`DCL_FLD_W-1:0]      lockStatusField,
  output logic [`DCL_CHANS-1:0]                      refUseExtPin,
  output logic [`DCL_CHANS-1:0]                      refUseBandGap,
  output logic [`DCL_CHANS-1:0]                      refUseSupply,
  output logic [`DCL_CHANS-1:0]                      refBufferOn,
  output logic [`DCL_CHANS-1:0]                      refDriveOn,
  // Bus address.
  output logic [`DCL_BUS_ADDR_W-1:0]                 storedBusAddressBits,
  output logic                                       slaveAddressLock
);
  import dcl_pkg::*;

  // ==========================================================================
  // Reset release.
  logic [1:0] rstPipe;
  logic       rstSync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync = rstPipe[1];

  // ==========================================================================
  // Address decoding.
  function automatic logic [`DCL_CHANS-1:0] chanHit(input logic [`DCL_ADDR_W-1:0] a,
                                                   input logic [`DCL_ADDR_W-1:0] base);
    logic [`DCL_CHANS-1:0] hit;
    hit = '0;
    for (int ch = 0; ch < `DCL_CHANS; ch++) begin
      hit[ch] = (a == base + `DCL_ADDR_W'(ch));
    end
    return hit;
  endfunction

  // ==========================================================================
  // State.
  localparam dcl_state_t RESET_STATE = '{
    phase:    DCL_RECALL,
    volDac:   {`DCL_CHANS{`DCL_CODE_MID}},
    nvDac:    {`DCL_CHANS{`DCL_CODE_MID}},
    volRef:   '0,
    nvRef:    '0,
    volPd:    '0,
    nvPd:     '0,
    volGain:  '0,
    nvGain:   '0,
    busAddr:  `DCL_BUS_ADDR_RST,
    slave_address_lock:    `DCL_SLAVE_ADDRESS_LOCK_RST,
    dataLock: '0,
    cfgLock:  '0,
    porFlag:  1'b1,
    rspValid: 1'b0,
    rspNack:  1'b0,
    rdData:   `DCL_WORD_ZERO
  };

  dcl_state_t q;
  dcl_state_t d;

  logic [`DCL_CHANS-1:0] volCodeOk;
  logic [`DCL_CHANS-1:0] nvCodeOk;
  logic [`DCL_CHANS-1:0] volCfgOk;
  logic [`DCL_CHANS-1:0] nvCfgOk;

  // ==========================================================================
  // Per-channel decoders.
  for (genvar g = 0; g < `DCL_CHANS; g++) begin : gChan
    dcl_lock_decode uLock (
      .dataLock   (q.dataLock[g]),
      .cfgLock    (q.cfgLock[g]),
      .volCodeOk  (volCodeOk[g]),
      .nvCodeOk   (nvCodeOk[g]),
      .volCfgOk   (volCfgOk[g]),
      .nvCfgOk    (nvCfgOk[g])
    );
    dcl_ref_decode uRef (
      .refSel     (q.volRef[g]),
      .pdSel      (q.volPd[g]),
      .useExtPin  (refUseExtPin[g]),
      .useBandGap (refUseBandGap[g]),
      .useSupply  (refUseSupply[g]),
      .bufferOn   (refBufferOn[g]),
      .refDriveOn (refDriveOn[g])
    );
  end

  // ==========================================================================
  // Next state.
  logic [`DCL_CHANS-1:0] hitVolDac;
  logic [`DCL_CHANS-1:0] hitNvDac;
  logic                  refused;
  logic                  mapped;
  logic                  lockCmd;

  always_comb begin
    d          = q;
    d.rspValid = 1'b0;
    d.rspNack  = 1'b0;
    hitVolDac  = chanHit(cmdAddr, `DCL_A_VOL_DAC0);
    hitNvDac   = chanHit(cmdAddr, `DCL_A_NV_DAC0);
    refused    = 1'b0;
    lockCmd    = (cmdKind == DCL_CMD_ENABLE);
    mapped     = (|hitVolDac) || (|hitNvDac) || (cmdAddr == `DCL_A_VOL_REF) ||
                 (cmdAddr == `DCL_A_VOL_PD) || (cmdAddr == `DCL_A_VOL_GAIN) ||
                 (cmdAddr == `DCL_A_LOCK_STAT) || (cmdAddr == `DCL_A_NV_REF) ||
                 (cmdAddr == `DCL_A_NV_PD) || (cmdAddr == `DCL_A_NV_GAIN);
    case (q.phase)
      DCL_RECALL: begin
        d.volDac  = q.nvDac;  // R21
        d.volRef  = q.nvRef;
        d.volPd   = q.nvPd;
        d.volGain = q.nvGain;
        d.porFlag = 1'b1;
        d.phase   = DCL_RUN;
      end
      DCL_RUN: begin
        if (porEvent) begin
          d.phase = DCL_RECALL;  // R21
        end else if (cmdValid) begin
          d.rspValid = 1'b1;
          case (cmdKind)
            DCL_CMD_WRITE: begin
              if (!mapped || (cmdAddr == `DCL_A_LOCK_STAT)) begin
                refused = 1'b1;
              end
              for (int ch = 0; ch < `DCL_CHANS; ch++) begin
                if (hitVolDac[ch]) begin
                  if (volCodeOk[ch]) d.volDac[ch] = cmdData[`DCL_RES-1:0];  // R08 R02 R03 R04 R05
                  else refused = 1'b1;                                       // R22
                end
                if (hitNvDac[ch]) begin
                  if (nvCodeOk[ch]) d.nvDac[ch] = cmdData[`DCL_RES-1:0];    // R08 R02 R03 R04 R05
                  else refused = 1'b1;                                       // R22
                end
                if (cmdAddr == `DCL_A_VOL_REF || cmdAddr == `DCL_A_VOL_PD ||
                    cmdAddr == `DCL_A_VOL_GAIN) begin
                  if (!volCfgOk[ch]) begin
                    refused = 1'b1;  // R06 R22
                  end else if (cmdAddr == `DCL_A_VOL_REF) begin
                    d.volRef[ch] = cmdData[ch*`DCL_FLD_W +: `DCL_FLD_W];  // R13 R17
                  end else if (cmdAddr == `DCL_A_VOL_PD) begin
                    d.volPd[ch] = cmdData[ch*`DCL_FLD_W +: `DCL_FLD_W];   // R06
                  end else begin
                    d.volGain[ch] = cmdData[`DCL_GAIN_LSB+ch];            // R06
                  end
                end
                if (cmdAddr == `DCL_A_NV_REF || cmdAddr == `DCL_A_NV_PD ||
                    cmdAddr == `DCL_A_NV_GAIN) begin
                  if (!nvCfgOk[ch]) begin
                    refused = 1'b1;  // R06 R22
                  end else if (cmdAddr == `DCL_A_NV_REF) begin
                    d.nvRef[ch] = cmdData[ch*`DCL_FLD_W +: `DCL_FLD_W];   // R13 R17
                  end else if (cmdAddr == `DCL_A_NV_PD) begin
                    d.nvPd[ch] = cmdData[ch*`DCL_FLD_W +: `DCL_FLD_W];    // R06
                  end else begin
                    d.nvGain[ch] = cmdData[`DCL_GAIN_LSB+ch];             // R06
                  end
                end
              end
              if (cmdAddr == `DCL_A_NV_GAIN) begin
                if (!q.slave_address_lock) d.busAddr = cmdData[`DCL_BUS_ADDR_W-1:0];  // R01
                else refused = 1'b1;                                      // R01 R22
              end
            end
            DCL_CMD_READ: begin
              d.rdData = `DCL_WORD_ZERO;
              if (!mapped) begin
                d.rdData = `DCL_WORD_RESERVED;
                refused  = 1'b1;
              end else if (cmdAddr == `DCL_A_VOL_REF) begin
                d.rdData = `DCL_WORD_W'(q.volRef);  // R13 R17
              end else if (cmdAddr == `DCL_A_NV_REF) begin
                d.rdData = `DCL_WORD_W'(q.nvRef);   // R13 R17
              end else if (cmdAddr == `DCL_A_VOL_PD) begin
                d.rdData = `DCL_WORD_W'(q.volPd);
              end else if (cmdAddr == `DCL_A_NV_PD) begin
                d.rdData = `DCL_WORD_W'(q.nvPd);
              end else if (cmdAddr == `DCL_A_VOL_GAIN) begin
                d.rdData = (`DCL_WORD_W'(q.volGain) << `DCL_GAIN_LSB) |
                           (`DCL_WORD_W'(q.porFlag) << `DCL_POR_BIT);
                d.porFlag = 1'b0;
              end else if (cmdAddr == `DCL_A_NV_GAIN) begin
                d.rdData = (`DCL_WORD_W'(q.nvGain) << `DCL_GAIN_LSB) |
                           (`DCL_WORD_W'(q.slave_address_lock) << `DCL_SLAVE_ADDRESS_LOCK_BIT) | `DCL_WORD_W'(q.busAddr);
              end else if (cmdAddr == `DCL_A_LOCK_STAT) begin
                for (int ch = 0; ch < `DCL_CHANS; ch++) begin
                  d.rdData[ch*`DCL_FLD_W + `DCL_LOCK_DL_OFS] = q.dataLock[ch];  // R07
                  d.rdData[ch*`DCL_FLD_W + `DCL_LOCK_CL_OFS] = q.cfgLock[ch];   // R07
                end
              end else begin
                for (int ch = 0; ch < `DCL_CHANS; ch++) begin
                  if (hitVolDac[ch]) d.rdData = `DCL_WORD_W'(q.volDac[ch]);  // R08 R09 R10 R11 R12
                  if (hitNvDac[ch]) d.rdData = `DCL_WORD_W'(q.nvDac[ch]);    // R08 R09 R10 R11 R12
                end
              end
            end
            default: begin
              if (!highVoltageCmdPin) begin
                refused = 1'b1;  // R18
              end else if (|hitVolDac) begin
                for (int ch = 0; ch < `DCL_CHANS; ch++) begin
                  if (hitVolDac[ch]) d.cfgLock[ch] = lockCmd;  // R19
                end
              end else if (|hitNvDac) begin
                for (int ch = 0; ch < `DCL_CHANS; ch++) begin
                  if (hitNvDac[ch]) d.dataLock[ch] = lockCmd;  // R19
                end
              end else if (cmdAddr == `DCL_A_NV_GAIN) begin
                d.slave_address_lock = lockCmd;  // R20
              end else begin
                refused = 1'b1;
              end
            end
          endcase
          d.rspNack = refused;
        end
      end
      default: begin
        d.phase = DCL_RECALL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs.
  always_comb begin
    cmdReady             = (q.phase == DCL_RUN) && !porEvent;
    rspValid             = q.rspValid;
    rspNack              = q.rspNack;
    rdData               = q.rdData;
    outputCode           = q.volDac;
    powerDownField       = q.volPd;
    outputGainBit        = q.volGain;
    storedBusAddressBits = q.busAddr;
    slaveAddressLock     = q.slave_address_lock;
    for (int ch = 0; ch < `DCL_CHANS; ch++) begin
      lockStatusField[ch] = {q.dataLock[ch], q.cfgLock[ch]};  // R07
    end
  end

  // ==========================================================================
  // Checks.
  logic wrTaken;
  logic rdTaken;
  assign wrTaken = cmdValid && cmdReady && (cmdKind == DCL_CMD_WRITE);
  assign rdTaken = cmdValid && cmdReady && (cmdKind == DCL_CMD_READ);

  a_addr_locked: assert property (@(posedge clk) disable iff (!rstSync)  // R01
    q.slave_address_lock |=> $stable(q.busAddr))
    else $error("Stored bus address changed while locked.");

  a_full_lock: assert property (@(posedge clk) disable iff (!rstSync)  // R02
    (wrTaken && q.dataLock[0] && q.cfgLock[0] && cmdAddr == `DCL_A_VOL_REF)
      |=> $stable(q.volRef[0]) && rspNack)
    else $error("Fully locked channel accepted a configuration write.");

  a_cfg_only: assert property (@(posedge clk) disable iff (!rstSync)  // R03
    (wrTaken && q.dataLock[0] && !q.cfgLock[0] && cmdAddr == `DCL_A_VOL_PD)
      |=> q.volPd[0] == $past(cmdData[`DCL_FLD_W-1:0]))
    else $error("Volatile power-down not written under partial lock.");

  a_nv_reject: assert property (@(posedge clk) disable iff (!rstSync)  // R04
    (wrTaken && !q.dataLock[0] && q.cfgLock[0] && cmdAddr == `DCL_A_NV_DAC0)
      |=> $stable(q.nvDac[0]) && rspValid && rspNack)
    else $error("Stored code changed under volatile-only lock.");

  a_open_write: assert property (@(posedge clk) disable iff (!rstSync)  // R05
    (wrTaken && !q.dataLock[0] && !q.cfgLock[0] && cmdAddr == `DCL_A_NV_DAC0)
      |=> q.nvDac[0] == $past(cmdData[`DCL_RES-1:0]) && !rspNack)
    else $error("Unlocked stored code write was lost.");

  a_lock_cmd: assert property (@(posedge clk) disable iff (!rstSync)  // R19
    (cmdValid && cmdReady && cmdKind == DCL_CMD_ENABLE && highVoltageCmdPin &&
     cmdAddr == `DCL_A_NV_DAC0) |=> lockStatusField[0][`DCL_LOCK_DL_OFS] && rspValid && !rspNack)
    else $error("Data lock not set by enable command.");

  a_code_clip: assert property (@(posedge clk) disable iff (!rstSync)  // R09
    (rdTaken && cmdAddr == `DCL_A_VOL_DAC0)
      |=> rspValid && rdData[`DCL_WORD_W-1:`DCL_RES] == '0)
    else $error("Unimplemented code bits read nonzero.");

  a_recall_copy: assert property (@(posedge clk) disable iff (!rstSync)  // R21
    (q.phase == DCL_RUN && porEvent)
      |=> (q.phase == DCL_RECALL) ##1 (q.volDac == q.nvDac && $stable(q.dataLock) && $stable(q.cfgLock)))
    else $error("Recall did not copy stored codes or disturbed locks.");

  a_bandgap_on: assert property (@(posedge clk) disable iff (!rstSync)  // R15
    (q.volRef[0] == `DCL_REF_BANDGAP && q.volPd[0] != `DCL_PD_NORMAL) |-> refDriveOn[0])
    else $error("Band gap reference dropped in power-down.");

endmodule

// ==== rtl/dcl_pkg.sv ====
// Types shared by the converter register bank files.
// Assumes the constants header is on the include path.
`include "dcl_lock_regs.svh"

package dcl_pkg;

  // ==========================================================================
  // Command kinds on the serial command port.
  typedef enum logic [1:0] {
    DCL_CMD_WRITE,
    DCL_CMD_READ,
    DCL_CMD_ENABLE,
    DCL_CMD_DISABLE
  } dcl_cmd_t;

  // ==========================================================================
  // Phases of the register bank.
  typedef enum logic {
    DCL_RECALL,
    DCL_RUN
  } dcl_phase_t;

  // ==========================================================================
  // Whole state of the register bank.
  typedef struct packed {
    dcl_phase_t                                 phase;
    logic [`DCL_CHANS-1:0][`DCL_RES-1:0]        volDac;
    logic [`DCL_CHANS-1:0][`DCL_RES-1:0]        nvDac;
    logic [`DCL_CHANS-1:0][`DCL_FLD_W-1:0]      volRef;
    logic [`DCL_CHANS-1:0][`DCL_FLD_W-1:0]      nvRef;
    logic [`DCL_CHANS-1:0][`DCL_FLD_W-1:0]      volPd;
    logic [`DCL_CHANS-1:0][`DCL_FLD_W-1:0]      nvPd;
    logic [`DCL_CHANS-1:0]                      volGain;
    logic [`DCL_CHANS-1:0]                      nvGain;
    logic [`DCL_BUS_ADDR_W-1:0]                 busAddr;
    logic                                       slave_address_lock;
    logic [`DCL_CHANS-1:0]                      dataLock;
    logic [`DCL_CHANS-1:0]                      cfgLock;
    logic                                       porFlag;
    logic                                       rspValid;
    logic                                       rspNack;
    logic [`DCL_WORD_W-1:0]                     rdData;
  } dcl_state_t;

endpackage

// ==== rtl/dcl_ref_decode.sv ====
// Decodes one channel's reference-select and power-down fields into analog controls.
// Assumes both fields come from flip-flops of the register bank.
`timescale 1ns/10ps
`include "dcl_lock_regs.svh"

module dcl_ref_decode (
  // Fields of the channel.
  input  wire logic [1:0] refSel,
  input  wire logic [1:0] pdSel,
  // Analog controls.
  output logic            useExtPin,
  output logic            useBandGap,
  output logic            useSupply,
  output logic            bufferOn,
  output logic            refDriveOn
);
  import dcl_pkg::*;

  // ==========================================================================
  // Source and buffer selection.
  always_comb begin
    useExtPin  = (refSel == `DCL_REF_EXT_BUF) || (refSel == `DCL_REF_EXT_UNBUF);  // R14
    useBandGap = (refSel == `DCL_REF_BANDGAP);                                    // R14
    useSupply  = (refSel == `DCL_REF_SUPPLY);                                     // R14
    bufferOn   = (refSel == `DCL_REF_EXT_BUF) || useBandGap;                      // R14
    refDriveOn = useBandGap || (bufferOn && (pdSel == `DCL_PD_NORMAL));           // R15
  end

endmodule

// ==== tb/dac_config_register_lock_tb_top.sv ====
// Self-checking bench of the converter register bank.
// Assumes the design package and dcl_cmd_master are compiled first.
`timescale 1ns/10ps

module dac_config_register_lock_tb_top;
  import dcl_pkg::*;
  localparam dcl_cmd_t RD = DCL_CMD_READ;
  localparam dcl_cmd_t WR = DCL_CMD_WRITE;
  localparam dcl_cmd_t EN = DCL_CMD_ENABLE;
  localparam dcl_cmd_t DI = DCL_CMD_DISABLE;
  logic clk = 1'b0, rst_n = 1'b0, porEvent = 1'b0;
  logic cmdValid, cmdReady, hv, rspValid, rspNack;
  dcl_cmd_t cmdKind;
  logic [4:0] cmdAddr;
  logic [15:0] cmdData, rdData, d;
  logic [1:0][11:0] outputCode;
  logic [1:0][1:0] lockSt;
  logic [6:0] busAddr;
  logic [1:0][1:0] pdF;
  logic [1:0] drv;
  logic sal;
  logic [17:0] e, expQ[$];
  int errorCnt = 0, checked = 0, cyc = 0;

  // ==========================================================================
  // Design and master model.
  dcl_lock_top dcl_lock_top_i (.clk(clk), .rst_n(rst_n), .porEvent(porEvent),
    .highVoltageCmdPin(hv), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspNack(rspNack),
    .rdData(rdData), .outputCode(outputCode), .powerDownField(pdF), .outputGainBit(),
    .lockStatusField(lockSt), .refUseExtPin(), .refUseBandGap(), .refUseSupply(),
    .refBufferOn(), .refDriveOn(drv), .storedBusAddressBits(busAddr), .slaveAddressLock(sal));
  dcl_cmd_master dcl_cmd_master_i (.clk(clk), .cmdReady(cmdReady), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData), .highVoltageCmdPin(hv));

  always #5 clk = ~clk;

  // ==========================================================================
  // Comparison, verdict and hang guard.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finishTest;
    if (errorCnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errorCnt++;
      finishTest;
    end
  end

  // ==========================================================================
  // Answer watcher: oldest note against each answer.
  always @(negedge clk) begin
    if (rspValid === 1'b1) begin
      e = expQ.pop_front();
      chk(rspNack, e[16]);
      if (e[17]) chk(rdData, e[15:0]);
    end
  end

  task automatic cmd(input dcl_cmd_t k, input logic [4:0] a, input logic [15:0] v, input logic h,
                     input logic nk, input logic [15:0] rd);
    expQ.push_back({k == RD, nk, rd});
    dcl_cmd_master_i.send(k, a, v, h);
    @(negedge clk);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'h5fae));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cmd(RD, 5'h08, 16'h0000, 1'b0, 1'b0, 16'h0000);
    cmd(RD, 5'h00, 16'h0000, 1'b0, 1'b0, 16'h07ff);
    cmd(RD, 5'h02, 16'h0000, 1'b0, 1'b1, 16'hffff);
    d = 16'($urandom);
    cmd(WR, 5'h00, d, 1'b0, 1'b0, 16'h0000);
    chk(outputCode[0], d & 16'h0fff);
    cmd(RD, 5'h00, 16'h0000, 1'b0, 1'b0, d & 16'h0fff);
    cmd(EN, 5'h10, 16'h0000, 1'b0, 1'b1, 16'h0000);
    cmd(EN, 5'h10, 16'h0000, 1'b1, 1'b0, 16'h0000);
    chk(lockSt[0], 2'h2);
    cmd(RD, 5'h0b, 16'h0000, 1'b0, 1'b0, 16'h0002);
    cmd(WR, 5'h00, 16'h0123, 1'b0, 1'b1, 16'h0000);
    chk(outputCode[0], d & 16'h0fff);
    cmd(WR, 5'h08, 16'h0001, 1'b0, 1'b0, 16'h0000);
    cmd(WR, 5'h18, 16'h0001, 1'b0, 1'b1, 16'h0000);
    cmd(WR, 5'h09, 16'h0001, 1'b0, 1'b0, 16'h0000);
    chk(pdF[0], 2'h1);
    chk(drv[0], 1'b1);
    cmd(EN, 5'h00, 16'h0000, 1'b1, 1'b0, 16'h0000);
    cmd(WR, 5'h08, 16'h0003, 1'b0, 1'b1, 16'h0000);
    cmd(RD, 5'h08, 16'h0000, 1'b0, 1'b0, 16'h0001);
    cmd(DI, 5'h10, 16'h0000, 1'b1, 1'b0, 16'h0000);
    cmd(WR, 5'h00, 16'h0456, 1'b0, 1'b0, 16'h0000);
    cmd(WR, 5'h10, 16'h0456, 1'b0, 1'b1, 16'h0000);
    cmd(DI, 5'h00, 16'h0000, 1'b1, 1'b0, 16'h0000);
    cmd(WR, 5'h08, 16'h0000, 1'b0, 1'b0, 16'h0000);
    chk(drv[0], 1'b0);
    cmd(WR, 5'h10, 16'h0abc, 1'b0, 1'b0, 16'h0000);
    cmd(WR, 5'h18, 16'h0002, 1'b0, 1'b0, 16'h0000);
    cmd(EN, 5'h00, 16'h0000, 1'b1, 1'b0, 16'h0000);
    @(posedge clk);
    porEvent <= 1'b1;
    @(posedge clk);
    porEvent <= 1'b0;
    cmd(RD, 5'h00, 16'h0000, 1'b0, 1'b0, 16'h0abc);
    cmd(RD, 5'h0b, 16'h0000, 1'b0, 1'b0, 16'h0001);
    cmd(DI, 5'h00, 16'h0000, 1'b1, 1'b0, 16'h0000);
    cmd(WR, 5'h1a, 16'h0033, 1'b0, 1'b1, 16'h0000);
    chk(busAddr, 16'h0060);
    chk(sal, 1'b1);
    cmd(DI, 5'h1a, 16'h0000, 1'b1, 1'b0, 16'h0000);
    chk(sal, 1'b0);
    cmd(WR, 5'h1a, 16'h0033, 1'b0, 1'b0, 16'h0000);
    chk(busAddr, 16'h0033);
    @(negedge clk);
    chk(16'(expQ.size()), 16'h0000);
    finishTest;
  end
endmodule

// ==== tb/dcl_cmd_master.sv ====
// Command-port master model standing in for the serial front end.
// Assumes clk free running and the register bank's command port.
`timescale 1ns/10ps

module dcl_cmd_master (
  // Clock and flow control.
  input  wire logic             clk,
  input  wire logic             cmdReady,
  // Command request.
  output logic                  cmdValid,
  output dcl_pkg::dcl_cmd_t     cmdKind,
  output logic [4:0]            cmdAddr,
  output logic [15:0]           cmdData,
  output logic                  highVoltageCmdPin
);
  import dcl_pkg::*;

  // ==========================================================================
  // Idle levels.
  initial begin
    cmdValid = 1'b0;
    cmdKind = DCL_CMD_READ;
    cmdAddr = 5'h00;
    cmdData = 16'h0000;
    highVoltageCmdPin = 1'b0;
  end

  // ==========================================================================
  // One command, held until the bank takes it.
  task automatic send(input dcl_cmd_t k, input logic [4:0] a, input logic [15:0] d, input logic hv);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdAddr <= a;
    cmdData <= d;
    highVoltageCmdPin <= hv;
    do @(negedge clk); while (cmdReady !== 1'b1);
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdData <= ~d;
  endtask
endmodule
